// >>> common/pps_defs.vh
// Purpose: shared constants for the power sequencer control logic
// Assumes: 125 MHz system clock
// Notes: timing counts derive from printed times and the clock rate
`ifndef PPS_DEFS_VH
`define PPS_DEFS_VH
// Clock period in picoseconds
`define PPS_CLK_PERIOD_PS 8000
// Reset pulse and light-load hold-off, in milliseconds
`define PPS_HOLD_MS 200
// Cycles in the hold interval: 200 ms at 8 ns is exactly 25,000,000
`define PPS_HOLD_CYCLES 25'h17D_7840
// Synchroniser reset: wake idles high as its pull-up holds it
`define PPS_SYNC_RST 13'h1000
// Width of the hold counter
`define PPS_CNT_W 25
// Source select codes
`define PPS_SRC_NONE 2'h0
`define PPS_SRC_WALL 2'h1
`define PPS_SRC_USB 2'h2
`define PPS_SRC_BATT 2'h3
`endif

// >>> hw/pps_power_sequencer.v
// Purpose: turn-on, source select and reset timing of a portable power manager
// Assumes: analog comparators deliver thresholds as asynchronous levels
// Notes: open-drain pins are given as output enables, low while pulling low
// Notes: the hold count is a parameter so a bench may shorten it
`timescale 1ns/1ps
`include "pps_defs.vh"
module pps_power_sequencer #(
  parameter [24:0] HOLD_CYCLES = `PPS_HOLD_CYCLES
) (
  // Clock and reset
  input wire clock_i,
  input wire rst_n_i,
  // Push-button and controller inputs
  input wire wake_n_i,
  input wire hold_alive_i,
  input wire second_rail_req_i,
  input wire light_load_sel_i,
  input wire usb_high_power_i,
  input wire usb_suspend_i,
  // Comparator results
  input wire adapter_sense_i,
  input wire usb_above_3v9_i,
  input wire usb_above_4v0_i,
  input wire batt_above_3v0_i,
  input wire batt_above_2v6_i,
  input wire rail_above_3v9_i,
  input wire rail_above_3v1_i,
  input wire rail_at_batt_i,
  input wire usb_overload_i,
  // Converter and power path controls
  output wire conv1_en_o,
  output wire conv2_en_o,
  output wire batt_switch_on_o,
  output wire charger_en_o,
  output wire charge_current_en_o,
  output wire usb_limit_500_o,
  output wire pulse_mode_en_o,
  output wire [1:0] source_sel_o,
  output wire device_on_o,
  // Open-drain flags, enable low means pulled low
  output wire reset_out_o,
  output wire reset_out_oe_n_o,
  output wire key_state_n_o,
  output wire key_state_n_oe_n_o,
  output wire charging_n_o,
  output wire charging_n_oe_n_o
);

  // Sequencer states, one-hot
  // OFF keeps every enable low and holds the controller in reset
  // RAMP closes the power path and waits for the rail to reach battery
  // RUN enables the converters and times the reset and hold-off
  localparam [2:0] ST_OFF = 3'b001;
  localparam [2:0] ST_RAMP = 3'b010;
  localparam [2:0] ST_RUN = 3'b100;

  // Comparator and pin levels arrive with no relation to the clock,
  // so each costs two cycles of latency before any decision sees it
  // Synchroniser stages; the first stage feeds only the second
  reg [12:0] sync1_reg;
  reg [12:0] sync2_reg;
  wire [12:0] raw_in;
  assign raw_in = {wake_n_i, hold_alive_i, second_rail_req_i, light_load_sel_i,
    usb_suspend_i, adapter_sense_i, usb_above_3v9_i, usb_above_4v0_i,
    batt_above_3v0_i, batt_above_2v6_i, rail_above_3v9_i, rail_above_3v1_i,
    rail_at_batt_i};

  // The first stage may go metastable; only the second stage is read
  // Two-flop synchroniser for every pin input
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      // Wake idles high as its pull-up would hold it
      sync1_reg <= `PPS_SYNC_RST;
      sync2_reg <= `PPS_SYNC_RST;
    end else begin
      sync1_reg <= raw_in;
      sync2_reg <= sync1_reg;
    end
  end

  // Synchronised levels
  // Button and controller levels
  wire wake_n_s = sync2_reg[12];
  wire hold_s = sync2_reg[11];
  wire req2_s = sync2_reg[10];
  wire light_s = sync2_reg[9];
  // USB and wall levels
  wire susp_s = sync2_reg[8];
  wire wall_s = sync2_reg[7];
  wire usb39_s = sync2_reg[6];
  wire usb40_s = sync2_reg[5];
  // Battery and rail levels
  wire bat30_s = sync2_reg[4];
  wire bat26_s = sync2_reg[3];
  wire rail39_s = sync2_reg[2];
  wire rail31_s = sync2_reg[1];
  wire rail_ok_s = sync2_reg[0];

  // Overload and USB limit come from pins as well, so they are synchronised
  reg [1:0] ovl_sync_reg;
  reg [1:0] hp_sync_reg;
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ovl_sync_reg <= 2'b00;
      hp_sync_reg <= 2'b00;
    end else begin
      ovl_sync_reg <= {ovl_sync_reg[0], usb_overload_i};
      hp_sync_reg <= {hp_sync_reg[0], usb_high_power_i};
    end
  end

  // Power presence
  // Suspend removes USB presence even while the bus voltage is good
  // Wall presence outranks USB later, in the source choice
  wire wall_present = wall_s;
  wire usb_present = usb39_s & ~susp_s;
  wire ext_present = wall_present | usb_present;

  // Kept-on request from button or controller
  // The button alone keeps the device on only while it is held; the
  // controller must raise hold-alive before the button is let go
  wire kept_on = ~wake_n_s | hold_s;

  // Lockout: start and keep thresholds with hysteresis
  // Battery path when no external power, rail path when battery is low
  // Hysteresis: starting needs the higher threshold, staying the lower
  // A missing or flat battery still runs from a healthy rail
  wire start_ok = ext_present ? (bat30_s | rail39_s) : bat30_s;
  wire keep_ok = ext_present ? (bat26_s | rail31_s) : bat26_s;

  // Turn-on demand; external power wakes the device by itself
  // Trade-off: the controller cannot hold the device off on external power
  wire want_on = kept_on | ext_present;

  // Sequencer state, hold counter and hold-done flag
  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg [24:0] cnt_reg;
  reg [24:0] cnt_next;
  reg hold_done_reg;
  reg hold_done_next;

  // Next-state logic
  // Every loss of demand or lockout in RAMP or RUN passes OFF, which clears the count
  // Counter stops once the hold is served, so it cannot wrap while running
  always @* begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    hold_done_next = hold_done_reg;
    case (state_reg)
      ST_OFF: begin
        cnt_next = 25'h000_0000;
        hold_done_next = 1'b0;
        if (want_on && start_ok) begin
          state_next = ST_RAMP;
        end
      end
      ST_RAMP: begin
        // Rail charges up through the switch before converters start
        // Losing demand or lockout during the ramp aborts the start
        if (!want_on || !keep_ok) begin
          state_next = ST_OFF;
        end else if (rail_ok_s) begin
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!want_on || !keep_ok) begin
          state_next = ST_OFF;
        end else if (!hold_done_reg) begin
          // Counter restarts on every power-up via ST_OFF
          if (cnt_reg == HOLD_CYCLES - 25'h000_0001) begin
            hold_done_next = 1'b1;
          end else begin
            cnt_next = cnt_reg + 25'h000_0001;
          end
        end
      end
      default: begin
        state_next = ST_OFF;
      end
    endcase
  end

  // State registers
  // Reset lands in OFF with the hold not yet served
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= ST_OFF;
      cnt_reg <= 25'h000_0000;
      hold_done_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      hold_done_reg <= hold_done_next;
    end
  end

  // Powered covers the ramp so the switch closes before converters start
  wire running = state_reg[2];
  wire powered = state_reg[1] | state_reg[2];

  // Source choice by fixed priority
  // None while off, so the power path is open in shutdown
  // External sources outrank the battery, wall before USB
  reg [1:0] src_next;
  always @* begin
    if (!powered) begin
      src_next = `PPS_SRC_NONE;
    end else if (wall_present) begin
      src_next = `PPS_SRC_WALL;
    end else if (usb_present) begin
      src_next = `PPS_SRC_USB;
    end else begin
      src_next = `PPS_SRC_BATT;
    end
  end

  // Registered controls
  // Every control leaves a flip-flop so no pin glitches on input skew;
  // the price is one more cycle of latency after the synchronisers
  reg [1:0] src_reg;
  reg conv1_reg;
  reg conv2_reg;
  reg bsw_reg;
  reg chg_reg;
  reg chg_cur_reg;
  reg pulse_reg;
  reg rst_pull_reg;
  reg key_pull_reg;
  reg usb500_reg;
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      src_reg <= `PPS_SRC_NONE;
      conv1_reg <= 1'b0;
      conv2_reg <= 1'b0;
      bsw_reg <= 1'b0;
      chg_reg <= 1'b0;
      chg_cur_reg <= 1'b0;
      pulse_reg <= 1'b0;
      rst_pull_reg <= 1'b1;
      key_pull_reg <= 1'b0;
      usb500_reg <= 1'b0;
    end else begin
      src_reg <= src_next;
      conv1_reg <= running;
      conv2_reg <= running & req2_s & kept_on;
      // Switch closes while powered without external power
      bsw_reg <= powered & ~ext_present;
      // Overload drops the charger completely
      chg_reg <= powered & ext_present & ~ovl_sync_reg[1];
      chg_cur_reg <= powered & ext_present & ~ovl_sync_reg[1]
        & (wall_present | usb40_s);
      // Pulse mode only after hold-off and on battery alone
      pulse_reg <= running & hold_done_reg & ~ext_present & light_s;
      // Reset pulled low until hold interval completes
      rst_pull_reg <= ~(running & hold_done_reg);
      key_pull_reg <= ~wake_n_s;
      usb500_reg <= hp_sync_reg[1];
    end
  end

  // Output drive
  // Device-on mirrors the RUN state directly, one cycle ahead of conv1
  assign conv1_en_o = conv1_reg;
  assign conv2_en_o = conv2_reg;
  assign batt_switch_on_o = bsw_reg;
  assign charger_en_o = chg_reg;
  assign charge_current_en_o = chg_cur_reg;
  assign usb_limit_500_o = usb500_reg;
  assign pulse_mode_en_o = pulse_reg;
  assign source_sel_o = src_reg;
  assign device_on_o = running;
  // Open-drain pins only ever drive zero
  // Charge status follows the charger enable itself, not the current gate
  assign reset_out_o = 1'b0;
  assign reset_out_oe_n_o = ~rst_pull_reg;
  assign key_state_n_o = 1'b0;
  assign key_state_n_oe_n_o = ~key_pull_reg;
  assign charging_n_o = 1'b0;
  assign charging_n_oe_n_o = ~chg_reg;

endmodule

// >>> bench/pps_power_sequencer_monitor.sv
// Purpose: checker for the power sequencer outputs
// Assumes: HOLD_CYCLES set small in simulation
// Notes: bound to the design top, ports only
`timescale 1ns/1ps
module pps_power_sequencer_monitor (
  // Clock, reset and watched inputs
  input wire clock_i,
  input wire rst_n_i,
  input wire wake_n_i,
  input wire light_load_sel_i,
  input wire usb_overload_i,
  input wire rail_at_batt_i,
  // Watched outputs
  input wire conv1_en_o,
  input wire conv2_en_o,
  input wire charger_en_o,
  input wire charge_current_en_o,
  input wire pulse_mode_en_o,
  input wire [1:0] source_sel_o,
  input wire device_on_o,
  input wire reset_out_oe_n_o,
  input wire key_state_n_oe_n_o,
  input wire charging_n_oe_n_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  conv2_gate_a: assert property (conv2_en_o |-> conv1_en_o && $past(device_on_o))
    else $error("second converter on alone");
  key_follow_a: assert property ($fell(wake_n_i) |-> ##[1:4] !key_state_n_oe_n_o)
    else $error("key flag missed press");
  reset_hold_a: assert property ($rose(device_on_o) |-> !reset_out_oe_n_o [*8])
    else $error("reset released early");
  // Pulse mode only after the hold and on battery alone
  pulse_gate_a: assert property (pulse_mode_en_o |-> reset_out_oe_n_o && source_sel_o == 2'h3)
    else $error("pulse mode not suppressed");
  pwm_force_a: assert property (!light_load_sel_i [*4] |=> !pulse_mode_en_o)
    else $error("pulse mode without select");
  chg_flag_a: assert property (charging_n_oe_n_o == !charger_en_o)
    else $error("charge flag not pulled");
  conv1_wait_a: assert property ($rose(conv1_en_o) |-> $past(rail_at_batt_i, 4))
    else $error("converter before rail");
  cur_gate_a: assert property (charge_current_en_o |-> charger_en_o)
    else $error("current without charger");
  usb_ovl_a: assert property ((usb_overload_i && source_sel_o == 2'h2) [*4] |=> !charger_en_o)
    else $error("charger kept on overload");
  cover property ($rose(device_on_o));
  cover property ($rose(reset_out_oe_n_o));
  cover property ($rose(pulse_mode_en_o));
endmodule
bind pps_power_sequencer pps_power_sequencer_monitor mon (.clock_i, .rst_n_i, .wake_n_i,
  .light_load_sel_i, .usb_overload_i, .rail_at_batt_i, .conv1_en_o, .conv2_en_o,
  .charger_en_o, .charge_current_en_o, .pulse_mode_en_o, .source_sel_o, .device_on_o,
  .reset_out_oe_n_o, .key_state_n_oe_n_o, .charging_n_oe_n_o);

// >>> bench/pps_button_model.sv
// Purpose: push-button and controller model
// Assumes: controller wakes once its reset pin is released
// Notes: open button reads high through the pull-up
`timescale 1ns/1ps
module pps_button_model (
  // Clock and command
  input wire clock_i,
  input wire press_i,
  // Device pins
  input wire device_on_i,
  input wire reset_oe_n_i,
  output wire wake_n_o,
  output reg hold_alive_o
);
  // Released switch leaves the line at the pull-up level
  assign wake_n_o = press_i ? 1'b0 : 1'b1;
  initial hold_alive_o = 1'b0;
  // Controller holds the device on only while out of reset
  always @(negedge clock_i) begin
    hold_alive_o <= device_on_i & reset_oe_n_i;
  end
endmodule

// >>> bench/test_pps_power_sequencer.sv
// Purpose: directed tests of the power sequencer
// Assumes: 125 MHz clock, short hold count
// Notes: inputs change on the falling edge
`timescale 1ns/1ps
module test_pps_power_sequencer;
  localparam HOLD = 20;
  reg clock_i = 1'b0;
  reg rst_n_i = 1'b0;
  reg press = 1'b0, req = 1'b0, ll = 1'b1, susp = 1'b0, wall = 1'b0, ovl = 1'b0;
  reg u39 = 1'b0, u40 = 1'b0, b30 = 1'b1, b26 = 1'b1, r39 = 1'b0, rail = 1'b0, hp = 1'b1;
  wire wake_n, hold, on, c1, c2, bsw, chg, ccur, u500, pulse, rst_oe_n, k_oe_n, ch_oe_n;
  wire [1:0] src;
  integer mismatches = 0, checks = 0, cycles = 0;
  pps_power_sequencer #(.HOLD_CYCLES(HOLD)) dut (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .wake_n_i(wake_n), .hold_alive_i(hold), .second_rail_req_i(req), .light_load_sel_i(ll),
    .usb_high_power_i(hp), .usb_suspend_i(susp), .adapter_sense_i(wall),
    .usb_above_3v9_i(u39), .usb_above_4v0_i(u40), .batt_above_3v0_i(b30),
    .batt_above_2v6_i(b26), .rail_above_3v9_i(r39), .rail_above_3v1_i(r39),
    .rail_at_batt_i(rail), .usb_overload_i(ovl), .conv1_en_o(c1), .conv2_en_o(c2),
    .batt_switch_on_o(bsw), .charger_en_o(chg), .charge_current_en_o(ccur),
    .usb_limit_500_o(u500), .pulse_mode_en_o(pulse), .source_sel_o(src), .device_on_o(on),
    .reset_out_o(), .reset_out_oe_n_o(rst_oe_n), .key_state_n_o(),
    .key_state_n_oe_n_o(k_oe_n), .charging_n_o(), .charging_n_oe_n_o(ch_oe_n));
  pps_button_model ctl (.clock_i(clock_i), .press_i(press), .device_on_i(on),
    .reset_oe_n_i(rst_oe_n), .wake_n_o(wake_n), .hold_alive_o(hold));
  initial forever #4 clock_i = ~clock_i;
  task check(input [8*6-1:0] name, input seen, input exp);
    begin
      checks = checks + 1;
      if (seen !== exp) begin
        mismatches = mismatches + 1;
        $display("unexpected %0s: expected %b, seen %b", name, exp, seen);
      end
    end
  endtask
  task step(input integer n);
    repeat (n) @(negedge clock_i);
  endtask
  task give_verdict;
    begin
      $display("checks %0d, mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  // A hang counts as a failure
  always @(posedge clock_i) begin
    cycles = cycles + 1;
    if (cycles == 3000) begin
      mismatches = mismatches + 1;
      give_verdict;
    end
  end
  initial begin
    step(8);
    rst_n_i = 1'b1;
    press = 1'b1;
    step(8);
    check("on", on, 1'b0);
    check("c1", c1, 1'b0);
    check("src", src === 2'h3, 1'b1);
    check("bsw", bsw, 1'b1);
    check("key", k_oe_n, 1'b0);
    rail = 1'b1;
    step(8);
    check("on", on, 1'b1);
    check("rst", rst_oe_n, 1'b0);
    check("pulse", pulse, 1'b0);
    check("c1", c1, 1'b1);
    step(HOLD + 8);
    check("rst", rst_oe_n, 1'b1);
    press = 1'b0;
    req = 1'b1;
    step(8);
    check("on", on, 1'b1);
    check("key", k_oe_n, 1'b1);
    check("pulse", pulse, 1'b1);
    check("c2", c2, 1'b1);
    ll = 1'b0;
    b30 = 1'b0;
    step(8);
    check("pulse", pulse, 1'b0);
    check("on", on, 1'b1);
    b26 = 1'b0;
    step(8);
    check("on", on, 1'b0);
    check("c2", c2, 1'b0);
    b26 = 1'b1;
    press = 1'b1;
    step(8);
    check("on", on, 1'b0);
    press = 1'b0;
    $display("battery test done");
    ll = 1'b1;
    wall = 1'b1;
    step(8);
    check("on", on, 1'b0);
    r39 = 1'b1;
    step(8);
    check("on", on, 1'b1);
    check("src", src === 2'h1, 1'b1);
    check("chgn", ch_oe_n, 1'b0);
    check("bsw", bsw, 1'b0);
    check("rst", rst_oe_n, 1'b0);
    u39 = 1'b1;
    step(8);
    check("src", src === 2'h1, 1'b1);
    wall = 1'b0;
    step(8);
    check("src", src === 2'h2, 1'b1);
    check("ccur", ccur, 1'b0);
    check("u500", u500, 1'b1);
    hp = 1'b0;
    step(8);
    check("u500", u500, 1'b0);
    hp = 1'b1;
    u40 = 1'b1;
    step(HOLD + 8);
    check("ccur", ccur, 1'b1);
    check("pulse", pulse, 1'b0);
    ovl = 1'b1;
    step(8);
    check("chg", chg, 1'b0);
    ovl = 1'b0;
    susp = 1'b1;
    step(8);
    check("src", src === 2'h2, 1'b0);
    $display("external power test done");
    give_verdict;
  end
endmodule
